// ==== smartcard_params.svh ====
// Register offsets, field positions, reset values and counts of the smartcard interface
`ifndef SMARTCARD_PARAMS_SVH
`define SMARTCARD_PARAMS_SVH
`define A_CTRL 4'h0
`define A_STAT 4'h1
`define A_CONT 4'h2
`define A_ETUH 4'h3
`define A_ETUL 4'h4
`define A_GTH 4'h5
`define A_GTL 4'h6
`define A_WTH 4'h7
`define A_WTM 4'h8
`define A_WTL 4'h9
`define A_TXB 4'ha
`define A_RXB 4'hb
`define A_MASK 4'hc
`define RST_CTRL 8'h00
`define RST_CONT 8'h08
`define RST_ETUH 8'h01
`define RST_ETUL 8'h74
`define RST_GTH 8'h00
`define RST_GTL 8'h0c
`define RST_WTH 8'h00
`define RST_WTM 8'h25
`define RST_WTL 8'h80
`define RST_GT_ACT 9'h00c
`define CB_SRST 7
`define CB_POL 6
`define CB_UART 3
`define CB_WAIT_TIMER_RUN 2
`define CB_RETRY 1
`define CB_BIT_CONVENTION_SELECT 0
`define KB_CLKSRC 7
`define KB_C8 5
`define KB_C4 4
`define KB_IO 3
`define KB_CLK 2
`define KB_RST 1
`define KB_VCC 0
`define EB_COMP 7
`define SB_TXC 2
`define SB_PAR 0
`define MSK_CONT 8'hbf
`define MSK_ETUH 8'h87
`define MSK_GTH 8'h01
`define MSK_MASK 8'h01
`define ETU_ZERO_LEN 12'h800
`define GUARD_SAT 9'h1ff
`define LAST_BIT 4'h9
`define ERR_BIT 4'ha
`define END_BIT 4'hb
`endif

// ==== smartcard_pkg.sv ====
// Types shared by the smartcard interface
`default_nettype none
package smartcard_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_TX, ST_TXCHK, ST_RX, ST_RXERR} uart_state_e;
  // Contact and supervision pins as seen by the block
  typedef struct packed {
    logic presence_switch;
    logic overcurrent;
    logic voltage_ok;
    logic io;
    logic c4;
    logic c8;
    logic rst;
  } pins_in_s;
  typedef struct packed {
    logic       io_oe;
    logic       clk;
    logic       rst;
    logic       c4;
    logic       c8;
    logic       vcc_en;
    logic [1:0] vsel;
  } pins_out_s;
endpackage
`default_nettype wire

// ==== smartcard_interface_regs.sv ====
// Smartcard interface: registers, contact pins, bit-period, guard and waiting timers, character UART
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`include "smartcard_params.svh"
`default_nettype none
module smartcard_interface_regs #(
  parameter logic [2:0] MAX_REPEAT = 3'd4
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  input  wire logic [3:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic [7:0]                   rdata,
  input  wire smartcard_pkg::pins_in_s pins_in,
  output smartcard_pkg::pins_out_s     pins_out,
  output logic                         parity_irq
);
  import smartcard_pkg::*;

  // Reverse and invert a byte for the inverse convention
  function automatic logic [7:0] bit_convention_select_byte(input logic [7:0] b, input logic inv);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7 - i];
    end
    return inv ? ~r : b;
  endfunction

  function automatic logic wr_at(input logic w, input logic [3:0] a, input logic [3:0] t);
    return w && (a == t);
  endfunction

  // Pin synchroniser: second stage is the only reader of the first
  pins_in_s sync1_q;
  pins_in_s sync2_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (ce)
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  logic [7:0]  ctrl_q, ctrl_d, cont_q, cont_d, etuh_q, etuh_d, etul_q, etul_d;
  logic [7:0]  gth_q, gth_d, gtl_q, gtl_d, wt2_q, wt2_d, wt1_q, wt1_d, wt0_q, wt0_d;
  logic [7:0]  txb_q, txb_d, mask_q, mask_d, rdata_q, rdata_d;
  uart_state_e st_q, st_d;
  logic [3:0]  bit_q, bit_d;
  logic [8:0]  sh_q, sh_d, save_q, save_d, guard_q, guard_d, gt_act_q, gt_act_d;
  logic [7:0]  rsh_q, rsh_d, rxb_q, rxb_d;
  logic [11:0] etu_cnt_q, etu_cnt_d;
  logic [2:0]  retry_q, retry_d;
  logic [23:0] wt_q, wt_d;
  logic        odd_q, odd_d, err_q, err_d, first_q, first_d, rep_q, rep_d, low_q, low_d;
  logic        txbe_q, txbe_d, txc_q, txc_d, rxc_q, rxc_d, par_q, par_d, irq_q, irq_d;
  pins_out_s   out_q, out_d;
  logic        present, uart, bit_convention_select, srst, tick, mid, expired, restart, wt_evt, wt_wr, io_fall;
  logic        pbad;
  logic [11:0] etu_len;
  logic [7:0]  rx_byte;

  // Shared decodes
  assign present = sync2_q.presence_switch ^ ctrl_q[`CB_POL];
  assign uart    = ctrl_q[`CB_UART];
  assign bit_convention_select    = ctrl_q[`CB_BIT_CONVENTION_SELECT];
  assign srst    = ctrl_q[`CB_SRST];
  assign etu_len = ({etuh_q[2:0], etul_q} == 11'h000) ? `ETU_ZERO_LEN : {1'b0, etuh_q[2:0], etul_q};
  assign tick    = (etu_cnt_q == 12'h000);
  assign mid     = (etu_cnt_q == {1'b0, etu_len[11:1]});
  assign expired = (guard_q >= gt_act_q);
  assign wt_wr   = wr_at(wr, addr, `A_WTH);
  assign io_fall = !sync2_q.io && low_q == 1'b0 && sh_q[8];
  assign rx_byte = bit_convention_select_byte(rsh_q, bit_convention_select);
  assign pbad    = ((^rsh_q) ^ sync2_q.io) != bit_convention_select;

  // Register file and read port; read data stands one cycle after the strobe
  always_comb
  begin
    ctrl_d  = ctrl_q;
    cont_d  = cont_q;
    etuh_d  = etuh_q;
    etul_d  = etul_q;
    gth_d   = gth_q;
    gtl_d   = gtl_q;
    wt2_d   = wt2_q;
    wt1_d   = wt1_q;
    wt0_d   = wt0_q;
    txb_d   = txb_q;
    mask_d  = mask_q;
    rdata_d = 8'h00;
    if (wr)
    begin
      case (addr)
        `A_CTRL: ctrl_d = wdata;
        `A_CONT: cont_d = wdata & `MSK_CONT;
        `A_ETUH: etuh_d = wdata & `MSK_ETUH;
        `A_ETUL: etul_d = wdata;
        `A_GTH:  gth_d  = wdata & `MSK_GTH;
        `A_GTL:  gtl_d  = wdata;
        `A_WTH:  wt2_d  = wdata;
        `A_WTM:  wt1_d  = wdata;
        `A_WTL:  wt0_d  = wdata;
        `A_TXB:  txb_d  = wdata;
        `A_MASK: mask_d = wdata & `MSK_MASK;
        default: ;
      endcase
    end
    // Card removal drops power at once, whatever software wrote
    if (!present)
    begin
      cont_d[`KB_VCC] = 1'b0;
    end
    if (rd)
    begin
      case (addr)
        `A_CTRL: rdata_d = ctrl_q;
        `A_STAT: rdata_d = {txbe_q, present, sync2_q.overcurrent, sync2_q.voltage_ok,
                            wt_q == 24'h000000, txc_q, rxc_q, par_q};
        `A_CONT: rdata_d = {cont_q[`KB_CLKSRC], 1'b0, sync2_q.c8, sync2_q.c4, sync2_q.io,
                            cont_q[`KB_CLK], sync2_q.rst, cont_q[`KB_VCC]};
        `A_ETUH: rdata_d = etuh_q;
        `A_ETUL: rdata_d = etul_q;
        `A_GTH:  rdata_d = gth_q;
        `A_GTL:  rdata_d = gtl_q;
        `A_WTH:  rdata_d = wt2_q;
        `A_WTM:  rdata_d = wt1_q;
        `A_WTL:  rdata_d = wt0_q;
        `A_TXB:  rdata_d = txb_q;
        `A_RXB:  rdata_d = rxb_q;
        `A_MASK: rdata_d = mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q  <= `RST_CTRL;
      cont_q  <= `RST_CONT;
      etuh_q  <= `RST_ETUH;
      etul_q  <= `RST_ETUL;
      gth_q   <= `RST_GTH;
      gtl_q   <= `RST_GTL;
      wt2_q   <= `RST_WTH;
      wt1_q   <= `RST_WTM;
      wt0_q   <= `RST_WTL;
      txb_q   <= 8'h00;
      mask_q  <= 8'h00;
      rdata_q <= 8'h00;
    end
    else if (ce)
    begin
      ctrl_q  <= ctrl_d;
      cont_q  <= cont_d;
      etuh_q  <= etuh_d;
      etul_q  <= etul_d;
      gth_q   <= gth_d;
      gtl_q   <= gtl_d;
      wt2_q   <= wt2_d;
      wt1_q   <= wt1_d;
      wt0_q   <= wt0_d;
      txb_q   <= txb_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // Character UART, bit-period, guard and waiting timers, flags and pins
  always_comb
  begin
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    save_d   = save_q;
    rsh_d    = rsh_q;
    rxb_d    = rxb_q;
    err_d    = err_q;
    retry_d  = retry_q;
    first_d  = first_q;
    rep_d    = rep_q;
    low_d    = low_q;
    txbe_d   = txbe_q;
    txc_d    = txc_q;
    rxc_d    = rxc_q;
    par_d    = par_q;
    restart  = wr_at(wr, addr, `A_ETUH);
    wt_evt   = 1'b0;
    // One clk cycle off odd bits keeps the average at half a cycle
    etu_cnt_d = etu_cnt_q - 12'h001;
    odd_d     = odd_q;
    if (tick)
    begin
      etu_cnt_d = etu_len - {11'h000, etuh_q[`EB_COMP] & ~odd_q} - 12'h001;
      odd_d     = ~odd_q;
    end
    // Guard counts bit periods since the last transmitted start bit
    guard_d  = guard_q;
    gt_act_d = gt_act_q;
    if (tick && guard_q != `GUARD_SAT)
    begin
      guard_d = guard_q + 9'h001;
    end
    if (expired)
    begin
      gt_act_d = {gth_q[0], gtl_q};
    end
    // Software clears go first so a hardware set in the same cycle wins
    if (wr_at(wr, addr, `A_STAT) && !wdata[`SB_TXC])
    begin
      txc_d = 1'b0;
    end
    if (wr_at(wr, addr, `A_STAT) && !wdata[`SB_PAR])
    begin
      par_d = 1'b0;
    end
    if (wr_at(rd, addr, `A_RXB))
    begin
      rxc_d = 1'b0;
    end
    case (st_q)
      ST_IDLE:
      begin
        low_d = 1'b0;
        // Transmission has priority over reception
        if (uart && (rep_q || !txbe_q) && (first_q || expired))
        begin
          if (!rep_q)
          begin
            save_d = {(^txb_q) ^ bit_convention_select, bit_convention_select_byte(txb_q, bit_convention_select)};
            txbe_d = 1'b1;
          end
          sh_d    = rep_q ? save_q : {(^txb_q) ^ bit_convention_select, bit_convention_select_byte(txb_q, bit_convention_select)};
          rep_d   = 1'b0;
          first_d = 1'b0;
          guard_d = 9'h000;
          low_d   = 1'b1;
          bit_d   = 4'h0;
          restart = 1'b1;
          wt_evt  = 1'b1;
          st_d    = ST_TX;
        end
        else if (uart && io_fall)
        begin
          bit_d   = 4'h0;
          restart = 1'b1;
          wt_evt  = 1'b1;
          st_d    = ST_RX;
        end
      end
      ST_TX:
      begin
        if (tick)
        begin
          bit_d = bit_q + 4'h1;
          if (bit_q == `LAST_BIT)
          begin
            low_d = 1'b0;
            err_d = 1'b0;
            st_d  = ST_TXCHK;
          end
          else
          begin
            low_d = ~sh_q[0];
            sh_d  = {1'b1, sh_q[8:1]};
          end
        end
      end
      ST_TXCHK:
      begin
        // Card signals refusal by holding the line low in this slot
        if (mid)
        begin
          err_d = !sync2_q.io;
        end
        if (tick)
        begin
          st_d = ST_IDLE;
          if (err_q && ctrl_q[`CB_RETRY] && retry_q != MAX_REPEAT)
          begin
            retry_d = retry_q + 3'h1;
            rep_d   = 1'b1;
          end
          else if (err_q)
          begin
            retry_d = 3'h0;
            par_d   = 1'b1;
          end
          else
          begin
            retry_d = 3'h0;
            txc_d   = 1'b1;
          end
        end
      end
      ST_RX:
      begin
        if (tick)
        begin
          bit_d = bit_q + 4'h1;
        end
        if (mid)
        begin
          if (bit_q == 4'h0 && sync2_q.io)
          begin
            st_d = ST_IDLE;
          end
          else if (bit_q != 4'h0 && bit_q != `LAST_BIT)
          begin
            rsh_d = {sync2_q.io, rsh_q[7:1]};
          end
          else if (bit_q == `LAST_BIT)
          begin
            if (pbad && ctrl_q[`CB_RETRY] && retry_q != MAX_REPEAT)
            begin
              retry_d = retry_q + 3'h1;
              st_d    = ST_RXERR;
            end
            else
            begin
              retry_d = 3'h0;
              rxb_d   = rx_byte;
              rxc_d   = 1'b1;
              par_d   = par_q | pbad;
              st_d    = ST_IDLE;
            end
          end
        end
      end
      ST_RXERR:
      begin
        if (tick)
        begin
          bit_d = bit_q + 4'h1;
        end
        if (mid && bit_q == `ERR_BIT)
        begin
          low_d = 1'b1;
        end
        else if (mid && bit_q == `END_BIT)
        begin
          low_d = 1'b0;
          st_d  = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (wr_at(wr, addr, `A_TXB))
    begin
      txbe_d = 1'b0;
    end
    if (restart)
    begin
      etu_cnt_d = etu_len - 12'h001;
      odd_d     = 1'b0;
    end
    // Waiting counter runs down at the bit rate; zero means overflow
    wt_d = wt_q;
    if (ctrl_q[`CB_WAIT_TIMER_RUN] && tick && wt_q != 24'h000000)
    begin
      wt_d = wt_q - 24'h000001;
    end
    if ((wt_wr && (!ctrl_q[`CB_WAIT_TIMER_RUN] || uart)) || (wt_evt && ctrl_q[`CB_WAIT_TIMER_RUN]))
    begin
      wt_d = {wt2_d, wt1_q, wt0_q};
    end
    // Soft reset holds the UART but leaves the settings alone
    if (srst)
    begin
      st_d    = ST_IDLE;
      low_d   = 1'b0;
      rep_d   = 1'b0;
      retry_d = 3'h0;
      first_d = 1'b1;
      txbe_d  = 1'b1;
      txc_d   = 1'b0;
      rxc_d   = 1'b0;
      par_d   = 1'b0;
    end
    // Pins; open drain IO only ever pulls low
    out_d.io_oe  = uart ? low_q : !cont_q[`KB_IO];
    out_d.clk    = cont_q[`KB_CLKSRC] ? ~out_q.clk : cont_q[`KB_CLK];
    out_d.rst    = cont_q[`KB_RST];
    out_d.c4     = cont_q[`KB_C4];
    out_d.c8     = cont_q[`KB_C8];
    out_d.vcc_en = cont_q[`KB_VCC] & present;
    out_d.vsel   = ctrl_q[5:4];
    irq_d        = par_q & mask_q[0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q      <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 9'h1ff;
      save_q    <= 9'h1ff;
      rsh_q     <= 8'h00;
      rxb_q     <= 8'h00;
      err_q     <= 1'b0;
      retry_q   <= 3'h0;
      first_q   <= 1'b1;
      rep_q     <= 1'b0;
      low_q     <= 1'b0;
      txbe_q    <= 1'b1;
      txc_q     <= 1'b0;
      rxc_q     <= 1'b0;
      par_q     <= 1'b0;
      etu_cnt_q <= 12'h000;
      odd_q     <= 1'b0;
      guard_q   <= 9'h000;
      gt_act_q  <= `RST_GT_ACT;
      wt_q      <= {`RST_WTH, `RST_WTM, `RST_WTL};
      out_q     <= '0;
      irq_q     <= 1'b0;
    end
    else if (ce)
    begin
      st_q      <= st_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      save_q    <= save_d;
      rsh_q     <= rsh_d;
      rxb_q     <= rxb_d;
      err_q     <= err_d;
      retry_q   <= retry_d;
      first_q   <= first_d;
      rep_q     <= rep_d;
      low_q     <= low_d;
      txbe_q    <= txbe_d;
      txc_q     <= txc_d;
      rxc_q     <= rxc_d;
      par_q     <= par_d;
      etu_cnt_q <= etu_cnt_d;
      odd_q     <= odd_d;
      guard_q   <= guard_d;
      gt_act_q  <= gt_act_d;
      wt_q      <= wt_d;
      out_q     <= out_d;
      irq_q     <= irq_d;
    end
  end

  assign rdata      = rdata_q;
  assign pins_out   = out_q;
  assign parity_irq = irq_q;
endmodule
`default_nettype wire

// ==== smartcard_interface_regs_assertions.sv ====
// Port-level checks of the smartcard interface registers and contact pins
`default_nettype none
module smartcard_regs_checker (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     ce,
  input wire logic [3:0]               addr,
  input wire logic [7:0]               wdata,
  input wire logic                     wr,
  input wire smartcard_pkg::pins_in_s  pins_in,
  input wire smartcard_pkg::pins_out_s pins_out,
  input wire logic                     parity_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import smartcard_pkg::*;
  logic [7:0] ctl_q;
  logic       src_q;
  logic       mask_q;
  logic       present;

  // Shadow of the written settings, so each check can name its cause
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_q  <= 8'h00;
      src_q  <= 1'b0;
      mask_q <= 1'b0;
    end
    else if (ce && wr)
    begin
      if (addr == 4'h0) ctl_q <= wdata;
      if (addr == 4'h2) src_q <= wdata[7];
      if (addr == 4'hc) mask_q <= wdata[0];
    end
  end
  assign present = pins_in.presence_switch ^ ctl_q[6];

  // One clock domain, so clocking and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  vsel_follows_a: assert property (ce && wr && addr == 4'h0 |-> ##2 pins_out.vsel == $past(wdata[5:4], 2))
    else $error("card voltage select did not follow the control write");
  manual_io_a: assert property (ce && wr && addr == 4'h2 && !ctl_q[3] |-> ##2 pins_out.io_oe == !$past(wdata[3], 2))
    else $error("manual io drive did not follow the contact write");
  aux_pins_a: assert property (ce && wr && addr == 4'h2 |->
    ##2 {pins_out.c8, pins_out.c4, pins_out.rst} == {$past(wdata[5], 2), $past(wdata[4], 2), $past(wdata[1], 2)})
    else $error("aux or reset pin did not follow the contact write");
  clk_level_a: assert property (ce && wr && addr == 4'h2 && !wdata[7] |-> ##2 pins_out.clk == $past(wdata[2], 2))
    else $error("card clock level did not follow the contact write");
  clk_running_a: assert property (src_q [*4] |-> pins_out.clk != $past(pins_out.clk))
    else $error("card clock not toggling with running source");
  power_cut_a: assert property ((!present) [*4] |-> !pins_out.vcc_en)
    else $error("card power requested with no card present");
  irq_masked_a: assert property ((!mask_q) [*3] |-> !parity_irq)
    else $error("parity interrupt raised while masked");
  soft_reset_a: assert property ((ctl_q[7] && ctl_q[3]) [*3] |-> !pins_out.io_oe)
    else $error("io driven while the character engine is held in reset");
endmodule

bind smartcard_interface_regs smartcard_regs_checker chk (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .pins_in(pins_in), .pins_out(pins_out), .parity_irq(parity_irq));
`default_nettype wire

// ==== smartcard_card_model.sv ====
// Behavioural card: decodes reader characters on the io wire and may refuse them
`default_nettype none
module card_model #(
  parameter int ETU = 12
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  listen,
  input  wire logic  io,
  input  wire logic  refuse,
  output logic       pull,
  output logic [8:0] frame,
  output logic       got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st;
  logic [3:0] idx;
  int         cnt;
  logic       prev;

  // Start edge, mid-bit samples of data and parity, then the error slot
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st    <= 2'd0;
      idx   <= 4'd0;
      cnt   <= 0;
      pull  <= 1'b0;
      got   <= 1'b0;
      prev  <= 1'b1;
      frame <= 9'h000;
    end
    else
    begin
      got  <= 1'b0;
      prev <= io;
      if (st == 2'd0)
      begin
        // Manual pin wiggling is not a character, so only listen when told
        if (listen && prev && !io)
        begin
          st  <= 2'd1;
          idx <= 4'd0;
          cnt <= ETU + ETU / 2 - 1;
        end
      end
      else if (cnt != 0)
        cnt <= cnt - 1;
      else if (st == 2'd1)
      begin
        frame <= {io, frame[8:1]};
        idx   <= idx + 4'd1;
        cnt   <= (idx == 4'd8) ? ETU / 2 - 1 : ETU - 1;
        got   <= (idx == 4'd8);
        st    <= (idx == 4'd8) ? 2'd2 : 2'd1;
      end
      else if (st == 2'd2)
      begin
        pull <= refuse;
        st   <= 2'd3;
        cnt  <= ETU - 1;
      end
      else
      begin
        pull <= 1'b0;
        st   <= 2'd0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== smartcard_interface_regs_tb_top.sv ====
// Self-checking bench for the smartcard interface registers and character engine
`default_nettype none
`include "smartcard_params.svh"
module smartcard_interface_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import smartcard_pkg::*;
  `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", n, e, s); end end
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        sw = 1'b0;
  logic        oc = 1'b0;
  logic        vok = 1'b0;
  logic        refuse = 1'b0;
  logic        listen = 1'b0;
  logic        ce = 1'b1;
  logic        tx_low = 1'b0;
  logic [9:0]  f10;
  logic        pull;
  logic        got;
  logic        irq;
  logic        io_wire;
  logic [8:0]  frame;
  logic [7:0]  rdata;
  logic [7:0]  b;
  logic [7:0]  br;
  logic [15:0] e16;
  logic [15:0] rq[$];
  logic [8:0]  fq[$];
  pins_in_s    pins_in;
  pins_out_s   pins_out;
  int          err_total = 0;
  int          compares = 0;
  int          rnd;

  always #50 clk = ~clk;
  // Open-drain io with pull-up; aux pins read back what is driven
  assign io_wire = ~(pins_out.io_oe | pull | tx_low);
  assign pins_in = '{presence_switch: sw, overcurrent: oc, voltage_ok: vok, io: io_wire,
                     c4: pins_out.c4, c8: pins_out.c8, rst: pins_out.rst};

  smartcard_interface_regs dut (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out), .parity_irq(irq));
  card_model #(.ETU(12)) card (.clk(clk), .rstn(rstn), .listen(listen), .io(io_wire), .refuse(refuse),
    .pull(pull), .frame(frame), .got(got));

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Expected value and mask are noted before the strobe goes out
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    rq.push_back({e, m});
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic summarize;
    `CHK("frames left", 0, fq.size())
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Read data and card frames are matched to the oldest note mid-cycle
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
  begin
    if (rd_d)
    begin
      e16 = rq.pop_front();
      `CHK("rdata", e16[15:8], rdata & e16[7:0])
    end
    if (got)
      `CHK("frame", fq.size() ? fq.pop_front() : 9'bx, frame)
  end

  initial
  begin
    rnd = $urandom(3);
    repeat (16) @(posedge clk);
    oc   <= rnd[0];
    vok  <= rnd[1];
    rstn <= 1'b1;
    idle(4);
    rd_reg(`A_CTRL, 8'h00, 8'hff);
    rd_reg(`A_STAT, {2'b10, oc, vok, 4'h0}, 8'hff);
    rd_reg(`A_ETUH, 8'h01, 8'hff);
    rd_reg(`A_ETUL, 8'h74, 8'hff);
    rd_reg(`A_GTH, 8'h00, 8'hff);
    rd_reg(`A_GTL, 8'h0c, 8'hff);
    rd_reg(4'hd, 8'h00, 8'hff);
    for (int v = 0; v < 4; v++)
    begin
      wr_reg(`A_CTRL, 8'(v << 4));
      idle(3);
      `CHK("vsel", 2'(v), pins_out.vsel)
    end
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    wr_reg(`A_CTRL, 8'h00);
    ce <= 1'b1;
    idle(3);
    `CHK("ce freeze", 2'h3, pins_out.vsel)
    wr_reg(`A_CTRL, 8'h00);
    // Presence needs two flops before the power bit may be set
    sw <= 1'b1;
    idle(3);
    wr_reg(`A_CONT, 8'h09);
    idle(4);
    `CHK("power on", 1'b1, pins_out.vcc_en)
    rd_reg(`A_STAT, 8'h40, 8'h40);
    wr_reg(`A_CTRL, 8'h40);
    idle(4);
    `CHK("power cut", 1'b0, pins_out.vcc_en)
    rd_reg(`A_STAT, 8'h00, 8'h40);
    wr_reg(`A_CTRL, 8'h00);
    repeat (4)
    begin
      b = 8'($urandom) & 8'h3e;
      wr_reg(`A_CONT, b);
      idle(4);
      rd_reg(`A_CONT, b, 8'hff);
      `CHK("io pin", ~b[3], pins_out.io_oe)
    end
    wr_reg(`A_CONT, 8'h8c);
    idle(6);
    wr_reg(`A_CONT, 8'h0c);
    idle(3);
    `CHK("clk stop", 1'b1, pins_out.clk)
    rd_reg(`A_CONT, 8'h0c, 8'hff);
    wr_reg(`A_WTL, 8'h00);
    wr_reg(`A_WTM, 8'h00);
    wr_reg(`A_WTH, 8'h00);
    idle(4);
    rd_reg(`A_STAT, 8'h08, 8'h08);
    wr_reg(`A_CTRL, 8'h88);
    idle(5);
    rd_reg(`A_STAT, 8'h80, 8'h87);
    wr_reg(`A_ETUH, 8'h00);
    wr_reg(`A_ETUL, 8'h0c);
    listen <= 1'b1;
    // One character in each convention, io bit already released
    for (int c = 0; c < 2; c++)
    begin
      wr_reg(`A_CTRL, 8'h08 | 8'(c));
      b = 8'($urandom);
      br = {<<{b}};
      fq.push_back(c ? {~^b, ~br} : {^b, b});
      wr_reg(`A_TXB, b);
      idle(180);
      rd_reg(`A_STAT, 8'h04, 8'h05);
      wr_reg(`A_STAT, 8'hfb);
      rd_reg(`A_STAT, 8'h00, 8'h04);
    end
    // Card refuses: once without retry, then five times with it
    wr_reg(`A_MASK, 8'h01);
    wr_reg(`A_CTRL, 8'h08);
    refuse <= 1'b1;
    b = 8'($urandom);
    fq.push_back({^b, b});
    wr_reg(`A_TXB, b);
    idle(200);
    rd_reg(`A_STAT, 8'h01, 8'h05);
    `CHK("irq", 1'b1, irq)
    wr_reg(`A_STAT, 8'hfe);
    idle(3);
    `CHK("irq clear", 1'b0, irq)
    wr_reg(`A_CTRL, 8'h0a);
    b = 8'($urandom);
    repeat (5) fq.push_back({^b, b});
    wr_reg(`A_TXB, b);
    idle(1200);
    rd_reg(`A_STAT, 8'h01, 8'h05);
    // Card sends one direct character; the model must not mistake it for ours
    wr_reg(`A_STAT, 8'hfe);
    listen <= 1'b0;
    idle(20);
    b   = 8'($urandom);
    f10 = {^b, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      tx_low <= ~f10[i];
      idle(12);
    end
    tx_low <= 1'b0;
    // No transmit follows before software has let the gap pass
    idle(24);
    rd_reg(`A_STAT, 8'h02, 8'h03);
    rd_reg(`A_RXB, b, 8'hff);
    rd_reg(`A_STAT, 8'h00, 8'h02);
    idle(2);
    summarize;
  end

  // Hang guard, well past the expected few thousand cycles
  initial
  begin
    #1_000_000;
    err_total++;
    summarize;
  end
endmodule
`default_nettype wire
